// [src/opcode_dispatch_pkg.sv]
/*
 * constants, layouts and types for the opcode dispatch front end.
 * assumes one clock domain and word addressing on the register bus.
 */
package opcode_dispatch_pkg;
    localparam int OP_W = 9;
    localparam int RSEL_W = 4;
    localparam int LATCH_W = 13;
    localparam int WORD_W = 36;
    localparam int ENTRY_W = 10;
    localparam int UADDR_W = 11;
    localparam int UWORD_W = 75;
    localparam int DT_DEPTH = 512;
    localparam int DT_PAIR_DEPTH = 256;
    localparam int UC_DEPTH = 1280;
    localparam int STACK_DEPTH = 4;
    localparam int DEPTH_W = 3;
    // instruction word fields
    localparam int OP_LSB = 0;
    localparam int RSEL_LSB = 9;
    // dispatch word layout
    localparam int FETCH_LSB = 0;
    localparam int STORE_LSB = 3;
    localparam int J_LSB = 14;
    localparam int CHECK_BIT = 24;
    // io instructions: top three opcode bits all set
    localparam logic [2:0] IO_OP_TOP = 3'h7;
    // jump-restore opcode, value arbitrary
    localparam logic [8:0] JUMP_RESTORE_OP = 9'h100;
    // register indices
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_DT_ADDR = 4'h2;
    localparam logic [3:0] REG_DT_DATA = 4'h3;
    localparam logic [3:0] REG_UC_ADDR = 4'h4;
    localparam logic [3:0] REG_UC_DATA0 = 4'h5;
    localparam logic [3:0] REG_UC_DATA1 = 4'h6;
    localparam logic [3:0] REG_UC_DATA2 = 4'h7;
    localparam int CTRL_RUN_BIT = 0;
    localparam int ST_IO_BIT = 16;
    localparam int ST_DEPTH_LSB = 17;
    localparam int ST_OVF_BIT = 20;
    localparam int ST_RUN_BIT = 21;
    typedef enum logic [1:0] {KIND_INSTR, KIND_TRAP, KIND_INTR} dispatch_kind_e;
endpackage

// [src/ucode_bus_if.sv]
/*
 * carries return-stack and microcode-store signals between the
 * dispatch control and its two storage modules.
 */
`timescale 1ns/100ps
interface ucode_bus_if;
    logic push;
    logic pop;
    logic [10:0] push_addr;
    logic [10:0] top_addr;
    logic [2:0] depth;
    logic overflow;
    logic wr_en;
    logic [10:0] wr_addr;
    logic [74:0] wr_data;
    logic [10:0] rd_addr;
    logic [74:0] rd_data;
    modport ctrl (output push, pop, push_addr, wr_en, wr_addr, wr_data, rd_addr,
        input top_addr, depth, overflow, rd_data);
    modport stack_side (input push, pop, push_addr, output top_addr, depth, overflow);
    modport store_side (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface

// [src/ucode_return_stack.sv]
/*
 * four-level microcode return-address stack.
 * assumes push and pop are single-cycle strobes from the sequencer.
 */
`timescale 1ns/100ps
module ucode_return_stack (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // stack port
    ucode_bus_if.stack_side sb
);
    logic [10:0] slot_q [opcode_dispatch_pkg::STACK_DEPTH];
    logic [2:0] depth_q;
    logic overflow_q;

    // depth and overflow, pop wins over push
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            depth_q <= 3'h0;
            overflow_q <= 1'b0;
        end
        else if (sb.pop)
        begin
            if (depth_q != 3'h0)
                depth_q <= depth_q - 3'h1;
        end
        else if (sb.push)
        begin
            if (depth_q == 3'(opcode_dispatch_pkg::STACK_DEPTH))
                overflow_q <= 1'b1; // fifth call dropped
            else
                depth_q <= depth_q + 3'h1;
        end
    end

    // slot storage
    always_ff @(posedge mclk)
    begin
        if (!sb.pop && sb.push && depth_q != 3'(opcode_dispatch_pkg::STACK_DEPTH))
            slot_q[depth_q[1:0]] <= sb.push_addr;
    end

    assign sb.top_addr = (depth_q == 3'h0) ? 11'h000 : slot_q[2'(depth_q - 3'h1)];
    assign sb.depth = depth_q;
    assign sb.overflow = overflow_q;
endmodule

// [src/microcode_store.sv]
/*
 * 1280-word microcode store with registered read.
 * assumes the loader writes every word before the microprogram runs.
 */
`timescale 1ns/100ps
module microcode_store (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // store port
    ucode_bus_if.store_side ub
);
    logic [74:0] mem [opcode_dispatch_pkg::UC_DEPTH];
    logic [74:0] rd_q;

    // loader write port
    always_ff @(posedge mclk)
    begin
        if (ub.wr_en && ub.wr_addr < 11'(opcode_dispatch_pkg::UC_DEPTH))
            mem[ub.wr_addr] <= ub.wr_data;
    end

    // read port, out-of-range reads give zero
    always_ff @(posedge mclk)
    begin
        if (srst)
            rd_q <= '0;
        else if (ub.rd_addr < 11'(opcode_dispatch_pkg::UC_DEPTH))
            rd_q <= mem[ub.rd_addr];
        else
            rd_q <= '0;
    end

    assign ub.rd_data = rd_q;
endmodule

// [src/opcode_dispatch_control.sv]
/*
 * opcode latch, dispatch table and register, microcode addressing.
 * assumes fetch and sequencer inputs synchronous to mclk and an
 * avalon-mm master that holds each request until waitrequest is low.
 */
// Overview of operation
// - latch holds 9-bit opcode in bits 0-8, register select in 9-12
// - latch follows fetch while load is high, holds once load drops
// - 512-entry dispatch table indexed by the latched opcode
// - dispatch register captures the addressed entry on dispatch with no interrupt or trap pending
// - captured entry drives fetch, store and entry outputs alone
// - next opcode may load while current one runs from saved entry
// - io instructions block further latch loads until a dispatch taken for an interrupt or trap
// - jump-restore forces entry bit 4 low, uses select as bits 7-10
// - fetch, store, entry 7-10 per opcode; check, 4, 1-3 per pair
// - 1280-word microcode store addressed by entry on executor entry
// - return stack nests microcode calls four levels deep
// - extension register takes whole fetched word
// - dispatch word: fetch 0-2, store 3-5, entry 14-23, check bit
// - interrupt beats trap, both beat executing the instruction
`timescale 1ns/100ps
module opcode_dispatch_control (
    // clock and reset
    input wire logic mclk,
    input wire logic srst,
    // avalon-mm register slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // instruction fetch
    input wire logic [35:0] fetch_word,
    input wire logic opcode_latch_load,
    output logic [12:0] opcode_latch,
    output logic [35:0] operand_extension_reg,
    output logic io_busy,
    // next-instruction dispatch
    input wire logic next_instruction_dispatch,
    input wire logic pi_pending,
    input wire logic trap_pending,
    output logic dispatch_valid,
    output opcode_dispatch_pkg::dispatch_kind_e dispatch_kind,
    output logic [2:0] dispatch_fetch,
    output logic [2:0] dispatch_store,
    output logic [9:0] dispatch_entry,
    output logic dispatch_check,
    // microsequencer
    input wire logic executor_enter,
    input wire logic ucode_call,
    input wire logic ucode_return,
    input wire logic [10:0] ucode_next_addr,
    output logic [10:0] micro_addr,
    output logic [74:0] microword
);
    typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_e;

    // build the 10-bit entry from per-opcode and per-pair pieces
    function automatic logic [9:0] entry_f(input logic [8:0] op, input logic [3:0] rsel,
        input logic [9:0] wide, input logic [4:0] pair);
        logic [9:0] e;
        e = {pair[2:0], pair[3], 2'h0, wide[3:0]};
        if (op == opcode_dispatch_pkg::JUMP_RESTORE_OP)
            e = {pair[2:0], 1'b0, 2'h0, rsel};
        return e;
    endfunction

    // opcode belongs to the io group
    function automatic logic is_io_f(input logic [8:0] op);
        return op[8:6] == opcode_dispatch_pkg::IO_OP_TOP;
    endfunction

    ucode_bus_if ub ();

    // wide: {fetch, store, entry 7-10}; pair: {check, entry 4, entry 1-3}
    logic [9:0] dt_wide [opcode_dispatch_pkg::DT_DEPTH];
    logic [4:0] dt_pair [opcode_dispatch_pkg::DT_PAIR_DEPTH];

    bus_state_e bus_state_q;
    logic wait_q;
    logic [31:0] rdata_q;
    logic run_q;
    logic [8:0] dt_addr_q;
    logic [10:0] uc_addr_q;
    logic [31:0] uc_lo_q;
    logic [31:0] uc_mid_q;
    logic [12:0] latch_q;
    logic [35:0] ext_q;
    logic io_busy_q;
    logic valid_q;
    opcode_dispatch_pkg::dispatch_kind_e kind_q;
    logic [2:0] fetch_q;
    logic [2:0] store_q;
    logic [9:0] entry_q;
    logic check_q;
    logic [10:0] uaddr_q;
    logic [10:0] uaddr_d;
    logic [8:0] cur_op;
    logic [3:0] cur_rsel;
    logic [9:0] cur_wide;
    logic [4:0] cur_pair;
    logic [9:0] cur_entry;
    logic bus_wr;
    logic load_ok;
    logic disp_go;
    logic [9:0] rd_wide;
    logic [4:0] rd_pair;
    logic [31:0] rd_mux;

    microcode_store u_store (
        .mclk(mclk),
        .srst(srst),
        .ub(ub.store_side)
    );

    ucode_return_stack u_stack (
        .mclk(mclk),
        .srst(srst),
        .sb(ub.stack_side)
    );

    // current table lookup from the latched opcode
    assign cur_op = latch_q[8:0];
    assign cur_rsel = latch_q[12:9];
    assign cur_wide = dt_wide[cur_op];
    assign cur_pair = dt_pair[cur_op[8:1]];
    assign cur_entry = entry_f(cur_op, cur_rsel, cur_wide, cur_pair);
    assign bus_wr = bus_state_q == BUS_ANSWER && avs_write;
    assign load_ok = opcode_latch_load && !io_busy_q;
    assign disp_go = next_instruction_dispatch && run_q;

    // table read-back in dispatch word layout
    assign rd_wide = dt_wide[dt_addr_q];
    assign rd_pair = dt_pair[dt_addr_q[8:1]];
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        unique case (avs_address)
            opcode_dispatch_pkg::REG_CTRL:
                rd_mux[opcode_dispatch_pkg::CTRL_RUN_BIT] = run_q;
            opcode_dispatch_pkg::REG_STATUS:
            begin
                rd_mux[12:0] = latch_q;
                rd_mux[opcode_dispatch_pkg::ST_IO_BIT] = io_busy_q;
                rd_mux[opcode_dispatch_pkg::ST_DEPTH_LSB +: 3] = ub.depth;
                rd_mux[opcode_dispatch_pkg::ST_OVF_BIT] = ub.overflow;
                rd_mux[opcode_dispatch_pkg::ST_RUN_BIT] = run_q;
            end
            opcode_dispatch_pkg::REG_DT_ADDR:
                rd_mux[8:0] = dt_addr_q;
            opcode_dispatch_pkg::REG_DT_DATA:
            begin
                rd_mux[opcode_dispatch_pkg::FETCH_LSB +: 3] = rd_wide[9:7];
                rd_mux[opcode_dispatch_pkg::STORE_LSB +: 3] = rd_wide[6:4];
                rd_mux[opcode_dispatch_pkg::J_LSB +: 10] =
                    entry_f(dt_addr_q, 4'h0, rd_wide, rd_pair);
                rd_mux[opcode_dispatch_pkg::CHECK_BIT] = rd_pair[4];
            end
            opcode_dispatch_pkg::REG_UC_ADDR:
                rd_mux[10:0] = uc_addr_q;
            opcode_dispatch_pkg::REG_UC_DATA0:
                rd_mux = uc_lo_q;
            opcode_dispatch_pkg::REG_UC_DATA1:
                rd_mux = uc_mid_q;
            default:
                rd_mux = 32'h0000_0000; // unmapped reads zero
        endcase
    end

    // bus handshake: one wait cycle, then answer
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            bus_state_q <= BUS_IDLE;
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end
        else
        begin
            unique case (bus_state_q)
                BUS_IDLE:
                    if (avs_read || avs_write)
                    begin
                        bus_state_q <= BUS_ANSWER;
                        wait_q <= 1'b0;
                        rdata_q <= avs_read ? rd_mux : 32'h0000_0000;
                    end
                BUS_ANSWER:
                begin
                    bus_state_q <= BUS_IDLE;
                    wait_q <= 1'b1;
                end
            endcase
        end
    end

    // control and loader address registers
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            run_q <= 1'b0;
            dt_addr_q <= 9'h000;
            uc_addr_q <= 11'h000;
            uc_lo_q <= 32'h0000_0000;
            uc_mid_q <= 32'h0000_0000;
        end
        else if (bus_wr)
        begin
            unique case (avs_address)
                opcode_dispatch_pkg::REG_CTRL:
                    run_q <= avs_writedata[opcode_dispatch_pkg::CTRL_RUN_BIT];
                opcode_dispatch_pkg::REG_DT_ADDR:
                    dt_addr_q <= avs_writedata[8:0];
                opcode_dispatch_pkg::REG_UC_ADDR:
                    uc_addr_q <= avs_writedata[10:0];
                opcode_dispatch_pkg::REG_UC_DATA0:
                    uc_lo_q <= avs_writedata;
                opcode_dispatch_pkg::REG_UC_DATA1:
                    uc_mid_q <= avs_writedata;
                default:
                    ;
            endcase
        end
    end

    // dispatch table loading, pair pieces shared by even/odd opcodes
    always_ff @(posedge mclk)
    begin
        if (bus_wr && avs_address == opcode_dispatch_pkg::REG_DT_DATA)
        begin
            dt_wide[dt_addr_q] <= {avs_writedata[opcode_dispatch_pkg::FETCH_LSB +: 3],
                avs_writedata[opcode_dispatch_pkg::STORE_LSB +: 3],
                avs_writedata[opcode_dispatch_pkg::J_LSB +: 4]};
            dt_pair[dt_addr_q[8:1]] <= {avs_writedata[opcode_dispatch_pkg::CHECK_BIT],
                avs_writedata[opcode_dispatch_pkg::J_LSB + 6],
                avs_writedata[opcode_dispatch_pkg::J_LSB + 7 +: 3]};
        end
    end

    // microcode word commit on the last data word
    assign ub.wr_en = bus_wr && avs_address == opcode_dispatch_pkg::REG_UC_DATA2;
    assign ub.wr_addr = uc_addr_q;
    assign ub.wr_data = {avs_writedata[10:0], uc_mid_q, uc_lo_q};

    // opcode latch and extension register
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            latch_q <= 13'h0000;
            ext_q <= 36'h0_0000_0000;
        end
        else if (load_ok)
        begin
            latch_q <= fetch_word[opcode_dispatch_pkg::OP_LSB +: 13];
            ext_q <= fetch_word;
        end
    end

    // io instructions hold the latch until a dispatch taken for an interrupt or trap
    always_ff @(posedge mclk)
    begin
        if (srst)
            io_busy_q <= 1'b0;
        else if (disp_go)
            io_busy_q <= !pi_pending && !trap_pending && is_io_f(cur_op);
    end

    // next-instruction dispatch with interrupt and trap priority
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            valid_q <= 1'b0;
            kind_q <= opcode_dispatch_pkg::KIND_INSTR;
            fetch_q <= 3'h0;
            store_q <= 3'h0;
            entry_q <= 10'h000;
            check_q <= 1'b0;
        end
        else
        begin
            valid_q <= disp_go;
            if (disp_go)
            begin
                if (pi_pending)
                    kind_q <= opcode_dispatch_pkg::KIND_INTR;
                else if (trap_pending)
                    kind_q <= opcode_dispatch_pkg::KIND_TRAP;
                else
                begin
                    kind_q <= opcode_dispatch_pkg::KIND_INSTR;
                    fetch_q <= cur_wide[9:7];
                    store_q <= cur_wide[6:4];
                    entry_q <= cur_entry;
                    check_q <= cur_pair[4];
                end
            end
        end
    end

    // microcode address selection
    always_comb
    begin
        uaddr_d = uaddr_q;
        if (executor_enter)
            uaddr_d = {1'b0, entry_q};
        else if (ucode_return)
            uaddr_d = ub.top_addr;
        else if (run_q)
            uaddr_d = ucode_next_addr;
    end

    always_ff @(posedge mclk)
    begin
        if (srst)
            uaddr_q <= 11'h000;
        else
            uaddr_q <= uaddr_d;
    end

    // stack strobes, call returns to the word after the caller
    assign ub.push = ucode_call && !executor_enter && !ucode_return;
    assign ub.pop = ucode_return && !executor_enter;
    assign ub.push_addr = 11'(uaddr_q + 11'h001);
    assign ub.rd_addr = uaddr_d;

    // outputs
    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign opcode_latch = latch_q;
    assign operand_extension_reg = ext_q;
    assign io_busy = io_busy_q;
    assign dispatch_valid = valid_q;
    assign dispatch_kind = kind_q;
    assign dispatch_fetch = fetch_q;
    assign dispatch_store = store_q;
    assign dispatch_entry = entry_q;
    assign dispatch_check = check_q;
    assign micro_addr = uaddr_q;
    assign microword = ub.rd_data;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);

    AST_LATCH_LOAD: assert property (load_ok |=> latch_q == $past(fetch_word[12:0]))
        else $error("latch did not take fetched opcode");
    AST_LATCH_HOLD: assert property (!opcode_latch_load |=> $stable(latch_q))
        else $error("latch changed without load");
    AST_EXT_REG: assert property (load_ok |=> ext_q == $past(fetch_word))
        else $error("extension register missed fetched word");
    AST_IO_HOLD: assert property (io_busy_q |-> ##1 $stable(latch_q))
        else $error("latch changed during io instruction");
    AST_DISP_ENTRY: assert property (disp_go && !pi_pending && !trap_pending
        |=> entry_q == $past(cur_entry) && kind_q == opcode_dispatch_pkg::KIND_INSTR)
        else $error("dispatch register missed table entry");
    AST_ENTRY_HOLD: assert property (!disp_go |=> $stable(entry_q) && !valid_q)
        else $error("dispatch register changed without dispatch");
    AST_PI_WINS: assert property (disp_go && pi_pending
        |=> valid_q && kind_q == opcode_dispatch_pkg::KIND_INTR)
        else $error("interrupt lost priority");
    AST_TRAP_NEXT: assert property (disp_go && !pi_pending && trap_pending
        |=> kind_q == opcode_dispatch_pkg::KIND_TRAP)
        else $error("trap lost priority");
    AST_JUMP_RESTORE_OP: assert property (disp_go && !pi_pending && !trap_pending
        && cur_op == opcode_dispatch_pkg::JUMP_RESTORE_OP
        |=> entry_q[6] == 1'b0 && entry_q[3:0] == $past(cur_rsel))
        else $error("jump-restore entry not substituted");
    AST_UC_ENTER: assert property (executor_enter |=> uaddr_q == {1'b0, $past(entry_q)})
        else $error("executor entry address wrong");
    AST_STACK_DEPTH: assert property (ub.depth <= 3'(opcode_dispatch_pkg::STACK_DEPTH))
        else $error("return stack deeper than four");
    AST_STACK_DROP: assert property (ub.push && ub.depth == 3'(opcode_dispatch_pkg::STACK_DEPTH)
        |=> ub.overflow && ub.depth == 3'(opcode_dispatch_pkg::STACK_DEPTH))
        else $error("call beyond four levels not dropped");
    AST_RESET_CLEAR: assert property ($fell(srst) |-> entry_q == 10'h000 && ub.depth == 3'h0)
        else $error("reset left stale dispatch state");
    AST_BUS_ANSWER: assert property ((avs_read || avs_write) && wait_q |-> ##[1:2] !wait_q)
        else $error("bus request not answered");

    COV_IO_DISPATCH: cover property (disp_go && is_io_f(cur_op) ##1 io_busy_q);
    COV_PREFETCH: cover property (valid_q && kind_q == opcode_dispatch_pkg::KIND_INSTR
        ##[1:4] load_ok);
    COV_STACK_FULL: cover property (ub.depth == 3'(opcode_dispatch_pkg::STACK_DEPTH));
endmodule

// [sim/sequencer_model.sv]
/*
 * behavioural fetch unit and microsequencer driving the dispatch front end.
 * assumes a free-running mclk; every task starts on a rising edge.
 */
`timescale 1ns/100ps
module sequencer_model (
    // clock
    input wire logic mclk,
    // fetch and dispatch
    output logic [35:0] fetch_word,
    output logic opcode_latch_load,
    output logic next_instruction_dispatch,
    output logic pi_pending,
    output logic trap_pending,
    // microsequencer
    output logic executor_enter,
    output logic ucode_call,
    output logic ucode_return,
    output logic [10:0] ucode_next_addr
);
    // idle levels at time zero
    initial
    begin
        fetch_word = 36'h0;
        {opcode_latch_load, next_instruction_dispatch, pi_pending, trap_pending} = 4'h0;
        {executor_enter, ucode_call, ucode_return} = 3'h0;
        ucode_next_addr = 11'h000;
    end

    // one fetch cycle; the released bus shows the inverse word
    task automatic fetch(input logic [35:0] w);
        @(posedge mclk);
        fetch_word <= w;
        opcode_latch_load <= 1'b1;
        @(posedge mclk);
        fetch_word <= ~w;
        opcode_latch_load <= 1'b0;
        @(negedge mclk);
    endtask

    // one dispatch strobe with interrupt and trap levels
    task automatic dispatch(input logic pi, input logic trap);
        @(posedge mclk);
        next_instruction_dispatch <= 1'b1;
        pi_pending <= pi;
        trap_pending <= trap;
        @(posedge mclk);
        {next_instruction_dispatch, pi_pending, trap_pending} <= 3'h0;
        @(negedge mclk);
    endtask

    // one sequencer pulse; next address held afterwards
    task automatic step(input logic en, input logic call, input logic ret,
        input logic [10:0] nxt);
        @(posedge mclk);
        {executor_enter, ucode_call, ucode_return} <= {en, call, ret};
        ucode_next_addr <= nxt;
        @(posedge mclk);
        {executor_enter, ucode_call, ucode_return} <= 3'h0;
        @(negedge mclk);
    endtask
endmodule

// [sim/testbench.sv]
/*
 * self-checking bench for the opcode dispatch front end.
 * assumes the sequencer model beside it and the design sources in src/.
 */
`timescale 1ns/100ps
module testbench;
    logic mclk, srst, avs_read, avs_write, avs_waitrequest, opcode_latch_load, io_busy;
    logic [3:0] avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [35:0] fetch_word, operand_extension_reg;
    logic [12:0] opcode_latch;
    logic next_instruction_dispatch, pi_pending, trap_pending, dispatch_valid, dispatch_check;
    opcode_dispatch_pkg::dispatch_kind_e dispatch_kind;
    logic [2:0] dispatch_fetch, dispatch_store;
    logic [9:0] dispatch_entry;
    logic executor_enter, ucode_call, ucode_return;
    logic [10:0] ucode_next_addr, micro_addr;
    logic [74:0] microword;
    wire [16:0] fields = {dispatch_fetch, dispatch_store, dispatch_entry, dispatch_check};
    int n_mismatch = 0;
    int comparisons = 0;
    int cycles = 0;

    opcode_dispatch_control opcode_dispatch_control_inst (.*);
    sequencer_model sequencer_model_inst (.*);

    // free-running 40 MHz clock
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // hang guard
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_mismatch++;
            report_and_stop();
        end
    end

    // verdict
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // compare and count
    task automatic chk(input string what, input logic [74:0] exp, input logic [74:0] got);
        comparisons++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // one avalon transfer held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        do @(posedge mclk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    // dispatch word image
    function automatic logic [31:0] mk(input logic [2:0] f, input logic [2:0] s,
        input logic [2:0] j13, input logic j4, input logic [3:0] j710, input logic c);
        return {7'h00, c, j13, j4, 2'h0, j710, 8'h00, s, f};
    endfunction

    // table entry write through the loader registers
    task automatic dt(input logic [31:0] op, input logic [31:0] d);
        bus(1'b1, opcode_dispatch_pkg::REG_DT_ADDR, op);
        bus(1'b1, opcode_dispatch_pkg::REG_DT_DATA, d);
    endtask

    // main sequence
    initial
    begin
        srst = 1'b1;
        {avs_read, avs_write} = 2'h0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        repeat (8) @(posedge mclk);
        srst <= 1'b0;
        bus(1'b0, opcode_dispatch_pkg::REG_STATUS, 32'h0);
        chk("status", 75'h0, q);
        bus(1'b0, 4'hC, 32'h0);
        chk("unmapped", 75'h0, q);
        // loader fills tables; even partner written after odd
        dt(32'h005, mk(3'h5, 3'h2, 3'h3, 1'b1, 4'hA, 1'b1));
        dt(32'h004, mk(3'h1, 3'h7, 3'h6, 1'b0, 4'h2, 1'b0));
        dt(32'h100, mk(3'h2, 3'h3, 3'h1, 1'b1, 4'hF, 1'b1));
        dt(32'h1C0, mk(3'h4, 3'h4, 3'h2, 1'b0, 4'h3, 1'b0));
        bus(1'b1, opcode_dispatch_pkg::REG_DT_ADDR, 32'h005);
        bus(1'b0, opcode_dispatch_pkg::REG_DT_DATA, 32'h0);
        chk("pair share", mk(3'h5, 3'h2, 3'h6, 1'b0, 4'hA, 1'b0), q);
        bus(1'b1, opcode_dispatch_pkg::REG_UC_ADDR, 32'h30A);
        bus(1'b1, opcode_dispatch_pkg::REG_UC_DATA0, 32'h9ABC_DEF0);
        bus(1'b1, opcode_dispatch_pkg::REG_UC_DATA1, 32'h1234_5678);
        bus(1'b1, opcode_dispatch_pkg::REG_UC_DATA2, 32'h5A5);
        bus(1'b1, opcode_dispatch_pkg::REG_CTRL, 32'h1);
        // fetch and dispatch an odd opcode
        sequencer_model_inst.fetch(36'h5_5AA5_1405);
        chk("latch", 75'h1405, opcode_latch);
        chk("extension", 75'h5_5AA5_1405, operand_extension_reg);
        sequencer_model_inst.dispatch(1'b0, 1'b0);
        chk("valid", 75'h1, dispatch_valid);
        chk("fields", {3'h5, 3'h2, 10'h30A, 1'b0}, fields);
        chk("latch held", 75'h1405, opcode_latch);
        // prefetch of the jump-restore word
        sequencer_model_inst.fetch(36'h0_0000_1300);
        chk("prefetch", 75'h1300, opcode_latch);
        chk("saved fields", {3'h5, 3'h2, 10'h30A, 1'b0}, fields);
        // executor entry and four nested calls
        sequencer_model_inst.step(1'b1, 1'b0, 1'b0, 11'h001);
        chk("entry addr", 75'h30A, micro_addr);
        chk("microword", {11'h5A5, 32'h1234_5678, 32'h9ABC_DEF0}, microword);
        for (int k = 1; k <= 4; k++)
            sequencer_model_inst.step(1'b0, 1'b1, 1'b0, 11'(k * 32));
        bus(1'b0, opcode_dispatch_pkg::REG_STATUS, 32'h0);
        chk("depth", 75'h4, q[20:17]);
        sequencer_model_inst.step(1'b0, 1'b1, 1'b0, 11'h0A0);
        bus(1'b0, opcode_dispatch_pkg::REG_STATUS, 32'h0);
        chk("overflow", 75'hC, q[20:17]);
        for (int k = 3; k >= 0; k--)
        begin
            sequencer_model_inst.step(1'b0, 1'b0, 1'b1, 11'h000);
            chk("return", (k == 0) ? 75'h2 : 75'(k * 32 + 1), micro_addr);
        end
        sequencer_model_inst.step(1'b0, 1'b0, 1'b1, 11'h000);
        chk("empty return", 75'h0, micro_addr);
        // jump-restore subtype in the entry
        sequencer_model_inst.dispatch(1'b0, 1'b0);
        chk("jump restore", {3'h2, 3'h3, 10'h089, 1'b1}, fields);
        // io instruction keeps the latch
        sequencer_model_inst.fetch(36'h0_0000_01C0);
        sequencer_model_inst.dispatch(1'b0, 1'b0);
        chk("io busy", 75'h1, io_busy);
        sequencer_model_inst.fetch(36'h5_5AA5_1405);
        chk("io latch", 75'h1C0, opcode_latch);
        // interrupt beats trap beats instruction
        sequencer_model_inst.dispatch(1'b1, 1'b1);
        chk("kind intr", opcode_dispatch_pkg::KIND_INTR, dispatch_kind);
        chk("fields kept", {3'h4, 3'h4, 10'h103, 1'b0}, fields);
        sequencer_model_inst.dispatch(1'b0, 1'b1);
        chk("kind trap", opcode_dispatch_pkg::KIND_TRAP, dispatch_kind);
        // reset in mid-run, two edges so no check straddles its release
        @(posedge mclk);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        bus(1'b0, opcode_dispatch_pkg::REG_STATUS, 32'h0);
        chk("status reset", 75'h0, q);
        chk("fields reset", 75'h0, fields);
        sequencer_model_inst.dispatch(1'b0, 1'b0);
        chk("halted dispatch", 75'h0, dispatch_valid);
        report_and_stop();
    end
endmodule
